// file: logic/color_lut.v
// color lookup table with holding register, index and direct-color path
`timescale 1ns/1ps
`include "color_lut_consts.vh"

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - table of 256 entries, each a separate red, green, blue field
// - in table lookup, pixel bits are forced to zero where the mask bit is zero
// - data writes fill holding fields; entry written when all fields filled
// - step register picks the field, advances; orders RGB or RBG+dummy
// - RGB writes entry after third write; RBG order after fourth, discarded
// - write address comes from low index; high index not used by table
// - write to low index fetch alias loads holding register, bumps index
// - data read returns the stepped field and advances the step
// - after last field read, reload holding from next entry, bump index
// - direct color pixel: red 15:11, green 10:5, blue 4:0
// - direct-color fields drive converter msbs, lower bits held zero
// - coprocessor runs only in 8-bit mode over 16-bit display data
// - coprocessor logic and arithmetic act on single bytes
// - index port selects register; data ports B..F access it
module color_lut
(
   // clock and reset
   input wire ref_clk,
   input wire rst,
   // host byte port
   input wire [3:0] hostAddr,
   input wire hostWrite,
   input wire hostRead,
   input wire [7:0] hostWrData,
   output reg [7:0] hostRdData,
   // pixel stream
   input wire [15:0] pixelIn,
   input wire directColor,
   output reg [7:0] dacRed,
   output reg [7:0] dacGreen,
   output reg [7:0] dacBlue,
   // coprocessor byte lane mode
   output wire coprocByteMode
);

////////////////////////////////////////////////////////////////////////////
// storage
reg [7:0] lutRed [0:`LUT_DEPTH-1];
reg [7:0] lutGreen [0:`LUT_DEPTH-1];
reg [7:0] lutBlue [0:`LUT_DEPTH-1];

reg [7:0] regSel_r;
reg [7:0] indexLow_r;
reg [7:0] indexHigh_r;
reg [7:0] step_r;
reg [7:0] redHold_r;
reg [7:0] greenHold_r;
reg [7:0] blueHold_r;
reg [7:0] overlayHold_r;
reg [7:0] lutMask_r;

////////////////////////////////////////////////////////////////////////////
// decode
function isData;
   input [3:0] a;
   begin
      isData = (a >= `PORT_DATA_FIRST) && (a <= `PORT_DATA_LAST);
   end
endfunction

// next slot in the selected order; last slot wraps to red
function [2:0] nextSlot;
   input [2:0] slot;
   input order;
   begin
      case (slot)
         `SLOT_RED:
            nextSlot = (order == `ORDER_RBGX) ? `SLOT_BLUE : `SLOT_GREEN;
         `SLOT_BLUE:
            nextSlot = (order == `ORDER_RBGX) ? `SLOT_GREEN : `SLOT_RED;
         `SLOT_GREEN:
            nextSlot = (order == `ORDER_RBGX) ? `SLOT_DUMMY : `SLOT_BLUE;
         default:
            nextSlot = `SLOT_RED;
      endcase
   end
endfunction

// holding field picked by the slot; the dummy slot reads as zero
function [7:0] holdField;
   input [2:0] s;
   input [7:0] r;
   input [7:0] g;
   input [7:0] b;
   begin
      case (s)
         `SLOT_RED: holdField = r;
         `SLOT_GREEN: holdField = g;
         `SLOT_BLUE: holdField = b;
         default: holdField = 8'h00;
      endcase
   end
endfunction

wire dataWr = hostWrite && isData(hostAddr);
wire dataRd = hostRead && isData(hostAddr);
wire idxWr = hostWrite && (hostAddr == `PORT_INDEX);
wire order = step_r[`STEP_ORDER_BIT];
wire [2:0] slot = step_r[`STEP_SLOT_MSB:0];
wire [2:0] slotNxt = nextSlot(slot, order);
// a wrap back to red marks the last slot in either order
wire lastSlot = (slotNxt == `SLOT_RED);
wire lutSel = (regSel_r == `REG_COLOR_DATA);
wire lutWrDone = dataWr && lutSel && lastSlot;
wire lutRdDone = dataRd && lutSel && lastSlot;
wire fetchLow = dataWr && (regSel_r == `REG_INDEX_LOW_FETCH);
wire fetchHigh = dataWr && (regSel_r == `REG_INDEX_HIGH_FETCH);
// table reads bump index as a 16-bit value, as the fetch aliases do
wire [15:0] idxWord = {indexHigh_r, indexLow_r};
wire [15:0] idxInc = idxWord + 16'h0001;

////////////////////////////////////////////////////////////////////////////
// register writes
// plain writes land only outside the table and fetch paths
wire plainWr = dataWr && !lutSel && !fetchLow && !fetchHigh;
wire seqWr = dataWr && lutSel;
// table address for a fetch: written byte for the low alias, low index for the high alias
wire [7:0] fetchAddr = fetchLow ? hostWrData : indexLow_r;

always @(posedge ref_clk)
begin
   if (rst)
      regSel_r <= 8'h00;
   else if (idxWr)
      regSel_r <= hostWrData;
end

////////////////////////////////////////////////////////////////////////////
// shared index; fetch aliases count it as one 16-bit value
always @(posedge ref_clk)
begin
   if (rst)
   begin
      indexLow_r <= 8'h00;
      indexHigh_r <= 8'h00;
   end
   else if (fetchLow)
   begin
      {indexHigh_r, indexLow_r} <= {indexHigh_r, hostWrData}
         + 16'h0001;
   end
   else if (fetchHigh)
   begin
      {indexHigh_r, indexLow_r} <= {hostWrData, indexLow_r}
         + 16'h0001;
   end
   else if (lutWrDone)
   begin
      // write path wraps in 8 bits, high byte left alone
      indexLow_r <= indexLow_r + 8'h01;
   end
   else if (lutRdDone)
   begin
      {indexHigh_r, indexLow_r} <= idxInc;
   end
   else if (plainWr && regSel_r == `REG_INDEX_LOW)
   begin
      indexLow_r <= hostWrData;
   end
   else if (plainWr && regSel_r == `REG_INDEX_HIGH)
   begin
      indexHigh_r <= hostWrData;
   end
end

////////////////////////////////////////////////////////////////////////////
// field step
always @(posedge ref_clk)
begin
   if (rst)
      step_r <= 8'h00;
   else if (lutSel && (dataWr || dataRd))
      step_r[`STEP_SLOT_MSB:0] <= slotNxt;
   else if (plainWr && regSel_r == `REG_STEP)
      step_r <= hostWrData;
end

////////////////////////////////////////////////////////////////////////////
// holding register, one process per field; dummy slot data discarded
always @(posedge ref_clk)
begin
   if (rst)
      redHold_r <= 8'h00;
   else if (fetchLow || fetchHigh)
      redHold_r <= lutRed[fetchAddr];
   else if (seqWr && slot == `SLOT_RED)
      redHold_r <= hostWrData;
   else if (lutRdDone)
      redHold_r <= lutRed[indexLow_r];
   else if (plainWr && regSel_r == `REG_RED_HOLD)
      redHold_r <= hostWrData;
end

always @(posedge ref_clk)
begin
   if (rst)
      greenHold_r <= 8'h00;
   else if (fetchLow || fetchHigh)
      greenHold_r <= lutGreen[fetchAddr];
   else if (seqWr && slot == `SLOT_GREEN)
      greenHold_r <= hostWrData;
   else if (lutRdDone)
      greenHold_r <= lutGreen[indexLow_r];
   else if (plainWr && regSel_r == `REG_GREEN_HOLD)
      greenHold_r <= hostWrData;
end

always @(posedge ref_clk)
begin
   if (rst)
      blueHold_r <= 8'h00;
   else if (fetchLow || fetchHigh)
      blueHold_r <= lutBlue[fetchAddr];
   else if (seqWr && slot == `SLOT_BLUE)
      blueHold_r <= hostWrData;
   else if (lutRdDone)
      blueHold_r <= lutBlue[indexLow_r];
   else if (plainWr && regSel_r == `REG_BLUE_HOLD)
      blueHold_r <= hostWrData;
end

////////////////////////////////////////////////////////////////////////////
// overlay hold and pixel mask
always @(posedge ref_clk)
begin
   if (rst)
      overlayHold_r <= 8'h00;
   else if (plainWr && regSel_r == `REG_OVERLAY_HOLD)
      overlayHold_r <= hostWrData;
end

always @(posedge ref_clk)
begin
   if (rst)
      lutMask_r <= 8'hff;
   else if (plainWr && regSel_r == `REG_LUT_MASK)
      lutMask_r <= hostWrData;
end

////////////////////////////////////////////////////////////////////////////
// table write at the last slot, address from low index only
// no reset on the array: the table is not initialised
always @(posedge ref_clk)
begin
   if (lutWrDone)
      lutRed[indexLow_r] <= redHold_r;
end

// in RGB order the final blue byte lands in the entry in the same cycle
always @(posedge ref_clk)
begin
   if (lutWrDone)
      lutGreen[indexLow_r] <= (slot == `SLOT_GREEN) ? hostWrData
         : greenHold_r;
end

always @(posedge ref_clk)
begin
   if (lutWrDone)
      lutBlue[indexLow_r] <= (slot == `SLOT_BLUE) ? hostWrData
         : blueHold_r;
end

////////////////////////////////////////////////////////////////////////////
// read data
always @(posedge ref_clk)
begin
   if (rst)
      hostRdData <= 8'h00;
   else if (hostRead && hostAddr == `PORT_INDEX)
      hostRdData <= regSel_r;
   else if (dataRd)
   begin
      case (regSel_r)
         `REG_COLOR_DATA:
            hostRdData <= holdField(slot, redHold_r, greenHold_r,
               blueHold_r);
         `REG_INDEX_LOW: hostRdData <= indexLow_r;
         `REG_INDEX_LOW_FETCH: hostRdData <= indexLow_r;
         `REG_INDEX_HIGH: hostRdData <= indexHigh_r;
         `REG_INDEX_HIGH_FETCH: hostRdData <= indexHigh_r;
         `REG_STEP: hostRdData <= step_r;
         `REG_RED_HOLD: hostRdData <= redHold_r;
         `REG_GREEN_HOLD: hostRdData <= greenHold_r;
         `REG_BLUE_HOLD: hostRdData <= blueHold_r;
         `REG_OVERLAY_HOLD: hostRdData <= overlayHold_r;
         `REG_LUT_MASK: hostRdData <= lutMask_r;
         default: hostRdData <= 8'h00;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////
// pixel path, one cycle of latency
wire [7:0] lutAddr = pixelIn[7:0] & lutMask_r;

// direct-color fields; lower converter bits fixed at zero
wire [7:0] dcRed = {pixelIn[`DC_RED_MSB:`DC_RED_LSB], 3'h0};
wire [7:0] dcGreen = {pixelIn[`DC_GREEN_MSB:`DC_GREEN_LSB], 2'h0};
wire [7:0] dcBlue = {pixelIn[`DC_BLUE_MSB:`DC_BLUE_LSB], 3'h0};

always @(posedge ref_clk)
begin
   if (rst)
      dacRed <= 8'h00;
   else if (directColor)
      dacRed <= dcRed;
   else
      dacRed <= lutRed[lutAddr];
end

always @(posedge ref_clk)
begin
   if (rst)
      dacGreen <= 8'h00;
   else if (directColor)
      dacGreen <= dcGreen;
   else
      dacGreen <= lutGreen[lutAddr];
end

always @(posedge ref_clk)
begin
   if (rst)
      dacBlue <= 8'h00;
   else if (directColor)
      dacBlue <= dcBlue;
   else
      dacBlue <= lutBlue[lutAddr];
end

// coprocessor must treat 16-bit display data as bytes
assign coprocByteMode = directColor;

endmodule

// file: shared/color_lut_consts.vh
// register indices, field codes and widths for the color lookup table block
`ifndef COLOR_LUT_CONSTS_VH
`define COLOR_LUT_CONSTS_VH

// byte offsets of the direct-access ports
`define PORT_INDEX 4'ha
`define PORT_DATA_FIRST 4'hb
`define PORT_DATA_LAST 4'hf

// indexed register numbers
`define REG_INDEX_LOW 8'h60
`define REG_INDEX_HIGH 8'h61
`define REG_INDEX_LOW_FETCH 8'h62
`define REG_INDEX_HIGH_FETCH 8'h63
`define REG_STEP 8'h66
`define REG_RED_HOLD 8'h67
`define REG_GREEN_HOLD 8'h68
`define REG_BLUE_HOLD 8'h69
`define REG_OVERLAY_HOLD 8'h6b
`define REG_COLOR_DATA 8'h65
`define REG_LUT_MASK 8'h64

// step register layout: bits 2:0 field slot, bit 6 order select
`define STEP_SLOT_MSB 2
`define STEP_ORDER_BIT 6
`define ORDER_RGB 1'b0
`define ORDER_RBGX 1'b1

// slot codes
`define SLOT_RED 3'h0
`define SLOT_GREEN 3'h1
`define SLOT_BLUE 3'h2
`define SLOT_DUMMY 3'h3

// table shape
`define LUT_DEPTH 256
`define DAC_WIDTH 8

// direct-color field positions
`define DC_RED_MSB 15
`define DC_RED_LSB 11
`define DC_GREEN_MSB 10
`define DC_GREEN_LSB 5
`define DC_BLUE_MSB 4
`define DC_BLUE_LSB 0

`endif

// file: test/color_lut_sva.sv
// port assertions for the color lookup table
`timescale 1ns/1ps
`include "color_lut_consts.vh"
module color_lut_sva
(
   // clock and reset
   input wire ref_clk,
   input wire rst,
   // host byte port
   input wire [3:0] hostAddr,
   input wire hostWrite,
   input wire hostRead,
   input wire [7:0] hostWrData,
   input wire [7:0] hostRdData,
   // pixel stream
   input wire [15:0] pixelIn,
   input wire directColor,
   input wire [7:0] dacRed,
   input wire [7:0] dacGreen,
   input wire [7:0] dacBlue,
   input wire coprocByteMode
);
   logic [7:0] idxSeen_r;
   logic [7:0] maskSeen_r;
   wire dataPort = hostAddr >= `PORT_DATA_FIRST;
   ////////////////////////////////////////////////////////////////////////
   // shadow of index and mask, so refusal and masking can be judged
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         idxSeen_r <= 8'h00;
         maskSeen_r <= 8'hff;
      end
      else if (hostWrite && hostAddr == `PORT_INDEX)
         idxSeen_r <= hostWrData;
      else if (hostWrite && dataPort && idxSeen_r == `REG_LUT_MASK)
         maskSeen_r <= hostWrData;
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // same masked index twice, table untouched meanwhile
   sequence sameIdx;
      !directColor ##1 (!directColor && !hostWrite && !$past(hostWrite)
         && (pixelIn[7:0] & maskSeen_r) == $past(pixelIn[7:0] & maskSeen_r));
   endsequence
   AST_LUT_STABLE: assert property (sameIdx |=> $stable({dacRed, dacGreen, dacBlue}))
      else $error("converter outputs moved for same masked index");
   AST_RD_STABLE: assert property (!hostRead |=> $stable(hostRdData))
      else $error("read data changed without a read");
   AST_DC_RED: assert property (directColor |=> dacRed == {$past(pixelIn[15:11]), 3'h0})
      else $error("direct red wrong");
   AST_DC_GREEN: assert property (directColor |=> dacGreen == {$past(pixelIn[10:5]), 2'h0})
      else $error("direct green wrong");
   AST_DC_BLUE: assert property (directColor |=> dacBlue == {$past(pixelIn[4:0]), 3'h0})
      else $error("direct blue wrong");
   AST_BYTE_MODE: assert property (coprocByteMode == directColor)
      else $error("byte mode does not follow direct color");
   AST_UNMAPPED: assert property (hostRead && dataPort && idxSeen_r[7:4] == 4'h7 |=> hostRdData == 8'h00)
      else $error("unmapped register read not zero");
   AST_MASK_RD: assert property (hostRead && dataPort && idxSeen_r == `REG_LUT_MASK |=> hostRdData == maskSeen_r)
      else $error("mask read back wrong");
endmodule

// file: test/tb.sv
// self-checking bench for the color lookup table
`timescale 1ns/1ps
`include "color_lut_consts.vh"
module tb;
   logic ref_clk, rst, hostWrite, hostRead, directColor;
   logic [3:0] hostAddr;
   logic [7:0] hostWrData;
   logic [15:0] pixelIn;
   wire [7:0] hostRdData, dacRed, dacGreen, dacBlue;
   wire coprocByteMode;
   int n_fail, checks_done, i;
   color_lut color_lut_i (.ref_clk(ref_clk), .rst(rst), .hostAddr(hostAddr),
      .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
      .hostRdData(hostRdData), .pixelIn(pixelIn), .directColor(directColor),
      .dacRed(dacRed), .dacGreen(dacGreen), .dacBlue(dacBlue),
      .coprocByteMode(coprocByteMode));
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // one strobe, with an idle cycle so strobes never collide
   task acc(input logic [3:0] a, input logic [7:0] d, input logic w);
      @(negedge ref_clk);
      hostAddr = a;
      hostWrData = d;
      hostWrite = w;
      hostRead = !w;
      @(negedge ref_clk);
      hostWrite = 1'b0;
      hostRead = 1'b0;
   endtask
   task wr(input logic [7:0] r, input logic [7:0] d);
      acc(`PORT_INDEX, r, 1'b1);
      acc(`PORT_DATA_FIRST, d, 1'b1);
   endtask
   task rd(input logic [7:0] r, input logic [7:0] e);
      acc(`PORT_INDEX, r, 1'b1);
      acc(`PORT_DATA_LAST, 8'h00, 1'b0);
      chk(hostRdData, e);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, well past the scripted run
   initial
   begin
      #100000;
      n_fail++;
      stop_test;
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      n_fail = 0;
      checks_done = 0;
      rst = 1'b1;
      {hostAddr, hostWrite, hostRead, hostWrData, pixelIn} = '0;
      directColor = 1'b1; // table unknown until loaded
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      wr(`REG_INDEX_HIGH, 8'h33);
      wr(`REG_INDEX_LOW, 8'h05);
      acc(`PORT_INDEX, `REG_COLOR_DATA, 1'b1);
      for (i = 0; i < 6; i++)
         acc(4'hb + 4'(i % 5), 8'(8'h11 * (i + 1)), 1'b1);
      rd(`REG_INDEX_LOW, 8'h07);
      rd(`REG_INDEX_HIGH, 8'h33);
      rd(`REG_STEP, 8'h00);
      $display("test write order done");
      wr(`REG_INDEX_LOW_FETCH, 8'h05);
      rd(`REG_RED_HOLD, 8'h11);
      rd(`REG_BLUE_HOLD, 8'h33);
      acc(`PORT_INDEX, `REG_COLOR_DATA, 1'b1);
      for (i = 0; i < 6; i++)
      begin
         acc(4'hf - 4'(i % 5), 8'h00, 1'b0);
         chk(hostRdData, 8'(8'h11 * (i + 1)));
      end
      rd(`REG_INDEX_LOW, 8'h08);
      $display("test prefetch done");
      wr(`REG_STEP, 8'h40);
      wr(`REG_INDEX_LOW, 8'h0a);
      acc(`PORT_INDEX, `REG_COLOR_DATA, 1'b1);
      for (i = 0; i < 4; i++)
         acc(`PORT_DATA_FIRST, 8'(8'haa + 8'h11 * i), 1'b1);
      rd(`REG_STEP, 8'h40);
      rd(`REG_INDEX_LOW, 8'h0b);
      wr(`REG_STEP, 8'h00);
      wr(`REG_INDEX_LOW_FETCH, 8'h0a);
      rd(`REG_RED_HOLD, 8'haa);
      rd(`REG_GREEN_HOLD, 8'hcc);
      rd(`REG_BLUE_HOLD, 8'hbb);
      $display("test four step done");
      directColor = 1'b0;
      pixelIn = 16'h0005;
      @(negedge ref_clk);
      chk(dacRed, 8'h11);
      chk(dacBlue, 8'h33);
      wr(`REG_LUT_MASK, 8'h05);
      pixelIn = 16'hff0d;
      @(negedge ref_clk);
      chk(dacGreen, 8'h22);
      rd(`REG_LUT_MASK, 8'h05);
      $display("test pixel path done");
      // save and restore as an interrupt thread would; no fetch aliases
      wr(`REG_INDEX_LOW, 8'h3c);
      wr(`REG_RED_HOLD, 8'h6e);
      wr(`REG_INDEX_LOW, 8'h41);
      wr(`REG_RED_HOLD, 8'h00);
      wr(`REG_INDEX_LOW, 8'h3c);
      wr(`REG_RED_HOLD, 8'h6e);
      rd(`REG_INDEX_LOW, 8'h3c);
      rd(`REG_RED_HOLD, 8'h6e);
      $display("test save restore done");
      wr(`REG_LUT_MASK, 8'hff);
      wr(`REG_INDEX_LOW, 8'h20);
      acc(`PORT_INDEX, `REG_COLOR_DATA, 1'b1);
      acc(`PORT_DATA_FIRST, 8'h00, 1'b1);
      acc(`PORT_DATA_FIRST, 8'h5a, 1'b1);
      acc(`PORT_DATA_FIRST, 8'h00, 1'b1);
      pixelIn = 16'h0020;
      @(negedge ref_clk);
      chk(dacRed, 8'h00);
      chk(dacGreen, 8'h5a);
      // lower half loaded, as when the border bit is one
      wr(`REG_INDEX_LOW, 8'h00);
      acc(`PORT_INDEX, `REG_COLOR_DATA, 1'b1);
      for (i = 0; i < 384; i++)
         acc(`PORT_DATA_FIRST, (i % 3 == 2) ?
            8'(2 * ((i / 3) % 32)) : 8'h00, 1'b1);
      wr(`REG_INDEX_LOW_FETCH, 8'h7f);
      rd(`REG_BLUE_HOLD, 8'h3e);
      rd(`REG_RED_HOLD, 8'h00);
      rd(`REG_INDEX_LOW, 8'h80);
      $display("test mono and direct load done");
      directColor = 1'b1;
      pixelIn = 16'ha5c3;
      @(negedge ref_clk);
      chk(dacRed, 8'ha0);
      chk(dacGreen, 8'hb8);
      chk(dacBlue, 8'h18);
      chk({7'h00, coprocByteMode}, 8'h01);
      wr(8'h70, 8'h5a);
      rd(8'h70, 8'h00);
      $display("test direct and unmapped done");
      stop_test;
   end
endmodule
bind color_lut color_lut_sva color_lut_sva_i (.ref_clk(ref_clk), .rst(rst),
   .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
   .hostWrData(hostWrData), .hostRdData(hostRdData), .pixelIn(pixelIn),
   .directColor(directColor), .dacRed(dacRed), .dacGreen(dacGreen),
   .dacBlue(dacBlue), .coprocByteMode(coprocByteMode));
